// [design/sdpe_consts.svh]
// Timing and start-up constants for the speed/direction pulse encoder.
// Assumes a 40 MHz clock; counts derive from microsecond figures.
`ifndef SDPE_CONSTS_SVH
`define SDPE_CONSTS_SVH
`define SDPE_CLK_MHZ 40
`define SDPE_PRE_LOW_US 15
`define SDPE_SPEED_ONLY_US 30
`define SDPE_FORWARD_US 45
`define SDPE_REVERSE_US 90
`define SDPE_PRE_LOW_CYC (`SDPE_PRE_LOW_US * `SDPE_CLK_MHZ)
`define SDPE_SPEED_ONLY_CYC (`SDPE_SPEED_ONLY_US * `SDPE_CLK_MHZ)
`define SDPE_FORWARD_CYC (`SDPE_FORWARD_US * `SDPE_CLK_MHZ)
`define SDPE_REVERSE_CYC (`SDPE_REVERSE_US * `SDPE_CLK_MHZ)
`define SDPE_START_EDGES 2
`define SDPE_HYST_STARTUP 0
`define SDPE_DIR_STARTUP 2
`define SDPE_STARTUP_MISSING 1
`define SDPE_WRONG_DIR_MAX 1
`define SDPE_CNT_W 12
`endif

// [design/sdpe_pkg.sv]
// Types for the speed/direction pulse encoder.
// Assumes sdpe_consts.svh is compiled alongside.
package sdpe_pkg;
  typedef enum logic [1:0] {
    SDPE_IDLE = 2'b00,
    SDPE_PRE = 2'b01,
    SDPE_HIGH = 2'b10
  } sdpe_state_t;
  typedef enum logic [1:0] {
    SDPE_KIND_SPEED = 2'b00,
    SDPE_KIND_FWD = 2'b01,
    SDPE_KIND_REV = 2'b10
  } sdpe_kind_t;
  typedef struct packed {
    logic edge_seen;
    logic rising;
    logic dir_valid;
    logic dir_reverse;
  } sdpe_mag_t;
endpackage

// [design/sdpe_encoder.sv]
// Pulse-width encoder of a two-wire current speed/direction sensor.
// Assumes the front end delivers one-cycle magnetic transition strobes,
// edge polarity, and a direction verdict, all synchronous to i_clk.
// Operation
// [R01] First output pulse within two magnetic edges, on a rising edge.
// [R02] Hysteresis vibration suppression active straight from power-on.
// [R03] Direction suppression active after at most two output pulses.
// [R04] At start-up at most one (weak: three) pulses miss direction.
// [R05] After reversal at most one pulse carries the wrong direction.
// [R06] Each transition gives 15 us low before the high level; the code drops edges that arrive while a pulse is in progress.
// [R07] Speed pulses issued from power-on, before direction known.
// [R08] Speed-only pulse high for 30 us.
// [R09] Direction pulses high 45 us forward, 90 us reverse.
// [R10] Receiver classifies pulses by width thresholds.
// [R11] Receiver handles up to 12 kHz forward, 8 kHz reverse.
`timescale 1ns/1ps
`default_nettype none
`include "sdpe_consts.svh"
module sdpe_encoder
  import sdpe_pkg::*;
#(
  parameter int CNT_W = `SDPE_CNT_W
)(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire sdpe_mag_t i_mag,
  output logic o_current_high,
  output logic o_busy,
  output logic o_dir_suppress_on,
  output logic o_hyst_suppress_on,
  output sdpe_kind_t o_kind
);
  sdpe_state_t state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [CNT_W-1:0] width_ff, nxt_width;
  sdpe_kind_t kind_ff, nxt_kind;
  logic started_ff, nxt_started;
  logic [1:0] pulses_ff, nxt_pulses;
  logic high_ff, nxt_high;
  logic go;

  // Before the first pulse only a rising edge may start one
  assign go = i_mag.edge_seen && (started_ff || i_mag.rising); // [R01]

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_width = width_ff;
    nxt_kind = kind_ff;
    nxt_started = started_ff;
    nxt_pulses = pulses_ff;
    nxt_high = 1'b0;
    case (state_ff)
      SDPE_IDLE:
      begin
        // Edges during a pulse are dropped; front end limits the rate
        if (go)
        begin
          nxt_state = SDPE_PRE;
          nxt_cnt = CNT_W'(`SDPE_PRE_LOW_CYC - 1); // [R06]
          nxt_started = 1'b1;
          // Direction taken per pulse, so a reversal costs one pulse at most
          if (!i_mag.dir_valid)
          begin
            nxt_kind = SDPE_KIND_SPEED; // [R07]
            nxt_width = CNT_W'(`SDPE_SPEED_ONLY_CYC - 1); // [R08]
          end
          else if (i_mag.dir_reverse)
          begin
            nxt_kind = SDPE_KIND_REV; // [R05]
            nxt_width = CNT_W'(`SDPE_REVERSE_CYC - 1); // [R09]
          end
          else
          begin
            nxt_kind = SDPE_KIND_FWD;
            nxt_width = CNT_W'(`SDPE_FORWARD_CYC - 1); // [R09]
          end
        end
      end
      SDPE_PRE:
      begin
        if (cnt_ff == '0)
        begin
          nxt_state = SDPE_HIGH;
          nxt_cnt = width_ff;
          nxt_high = 1'b1;
        end
        else
          nxt_cnt = cnt_ff - 1'b1;
      end
      SDPE_HIGH:
      begin
        if (cnt_ff == '0)
        begin
          nxt_state = SDPE_IDLE;
          if (pulses_ff != 2'(`SDPE_DIR_STARTUP))
            nxt_pulses = pulses_ff + 1'b1; // [R03]
        end
        else
        begin
          nxt_cnt = cnt_ff - 1'b1;
          nxt_high = 1'b1;
        end
      end
      default:
        nxt_state = SDPE_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_ff <= SDPE_IDLE;
      cnt_ff <= '0;
      width_ff <= '0;
      kind_ff <= SDPE_KIND_SPEED;
      started_ff <= 1'b0;
      pulses_ff <= '0;
      high_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      width_ff <= nxt_width;
      kind_ff <= nxt_kind;
      started_ff <= nxt_started;
      pulses_ff <= nxt_pulses;
      high_ff <= nxt_high;
    end
  end

  assign o_current_high = high_ff;
  assign o_busy = (state_ff != SDPE_IDLE);
  assign o_kind = kind_ff;
  assign o_hyst_suppress_on = 1'b1; // [R02]
  // Count reached means suppression by direction is enabled
  assign o_dir_suppress_on = (pulses_ff == 2'(`SDPE_DIR_STARTUP)); // [R03]

  logic [CNT_W-1:0] hi_len_ff;
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      hi_len_ff <= '0;
    else if (high_ff)
      hi_len_ff <= hi_len_ff + 1'b1;
    else
      hi_len_ff <= '0;
  end

  pre_low_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R06]
    (state_ff == SDPE_IDLE && go) |=> !o_current_high [*8] ##0 state_ff == SDPE_PRE)
    else $error("pre-low not held");
  first_rising_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R01]
    (state_ff == SDPE_IDLE && !started_ff && i_mag.edge_seen && !i_mag.rising)
      |=> state_ff == SDPE_IDLE)
    else $error("first pulse on falling edge");
  speed_width_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R08]
    ($fell(o_current_high) && kind_ff == SDPE_KIND_SPEED)
      |-> $past(hi_len_ff) == CNT_W'(`SDPE_SPEED_ONLY_CYC - 1))
    else $error("speed-only width wrong");
  fwd_width_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R09]
    ($fell(o_current_high) && kind_ff == SDPE_KIND_FWD)
      |-> $past(hi_len_ff) == CNT_W'(`SDPE_FORWARD_CYC - 1))
    else $error("forward width wrong");
  rev_width_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R09]
    ($fell(o_current_high) && kind_ff == SDPE_KIND_REV)
      |-> $past(hi_len_ff) == CNT_W'(`SDPE_REVERSE_CYC - 1))
    else $error("reverse width wrong");
  pulse_start_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R07]
    (state_ff == SDPE_IDLE && go) |-> ##[600:602] o_current_high)
    else $error("pulse did not start");
  dir_kind_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R05]
    (state_ff == SDPE_IDLE && go && i_mag.dir_valid)
      |=> o_kind == (i_mag.dir_reverse ? SDPE_KIND_REV : SDPE_KIND_FWD))
    else $error("direction kind wrong");
  dir_supp_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R03]
    $rose(o_dir_suppress_on) |-> $past(state_ff) == SDPE_HIGH)
    else $error("direction suppression enabled off a pulse end");
  hyst_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R02]
    o_hyst_suppress_on)
    else $error("hysteresis suppression off");

  speed_c: cover property (@(posedge i_clk) $fell(o_current_high) && kind_ff == SDPE_KIND_SPEED);
  fwd_c: cover property (@(posedge i_clk) $fell(o_current_high) && kind_ff == SDPE_KIND_FWD);
  rev_c: cover property (@(posedge i_clk) $fell(o_current_high) && kind_ff == SDPE_KIND_REV);
  supp_c: cover property (@(posedge i_clk) $rose(o_dir_suppress_on));
endmodule
`default_nettype wire

// [sim/sdpe_rx_model.sv]
// Receiver model: measures each high level of the current line.
// Assumes the encoder clock; reports width, class and a done strobe.
`timescale 1ns/1ps
`default_nettype none
module sdpe_rx_model
  import sdpe_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_current_high,
  output logic [12:0] o_width,
  output sdpe_kind_t o_kind,
  output logic o_done
);
  logic [12:0] cnt_ff;
  logic prev_ff;
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_ff <= 13'h0000;
      prev_ff <= 1'b0;
      o_width <= 13'h0000;
      o_done <= 1'b0;
    end
    else
    begin
      prev_ff <= i_current_high;
      cnt_ff <= i_current_high ? cnt_ff + 13'h0001 : 13'h0000;
      o_done <= prev_ff && !i_current_high;
      if (prev_ff && !i_current_high)
      begin
        o_width <= cnt_ff;
      end
    end
  end
  // Thresholds midway, so slow or fast clocks still classify
  assign o_kind = (o_width < 13'h05DC) ? SDPE_KIND_SPEED :
                  (o_width < 13'h0A8C) ? SDPE_KIND_FWD : SDPE_KIND_REV;
endmodule
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the pulse encoder with a receiver model.
// Assumes a 40 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import sdpe_pkg::*;
;
  typedef struct packed {logic r; logic v; logic d; sdpe_kind_t k; logic [12:0] w;} sdpe_row_t;
  logic clk, rst, cur, busy, dsup, hsup, rx_done;
  sdpe_mag_t mag;
  sdpe_kind_t kind, rx_kind;
  logic [12:0] rx_width;
  int n_errors = 0;
  int num_checks = 0;
  int n;
  sdpe_row_t rows [5] = '{'{1'b1, 1'b0, 1'b0, SDPE_KIND_SPEED, 13'h04B0},
    '{1'b1, 1'b1, 1'b0, SDPE_KIND_FWD, 13'h0708}, '{1'b0, 1'b1, 1'b1, SDPE_KIND_REV, 13'h0E10},
    '{1'b1, 1'b1, 1'b0, SDPE_KIND_FWD, 13'h0708}, '{1'b0, 1'b0, 1'b0, SDPE_KIND_SPEED, 13'h04B0}};
  sdpe_encoder DUT (.i_clk(clk), .i_rst(rst), .i_mag(mag), .o_current_high(cur),
    .o_busy(busy), .o_dir_suppress_on(dsup), .o_hyst_suppress_on(hsup), .o_kind(kind));
  sdpe_rx_model RX (.i_clk(clk), .i_rst(rst), .i_current_high(cur), .o_width(rx_width),
    .o_kind(rx_kind), .o_done(rx_done));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic edge_in(input logic r, input logic v, input logic d);
    @(negedge clk);
    mag = '{1'b1, r, v, d};
    @(negedge clk);
    mag.edge_seen = 1'b0;
  endtask
  task automatic wait_done();
    n = 0;
    while (rx_done !== 1'b1 && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #2000000;
    n_errors++;
    give_verdict();
  end
  initial
  begin
    rst = 1'b1;
    mag = '0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    chk({cur, busy, dsup, hsup}, 16'h0001);
    edge_in(1'b0, 1'b0, 1'b0);
    repeat (602) @(negedge clk);
    chk({cur, busy}, 16'h0000);
    for (int i = 0; i < 5; i++)
    begin
      edge_in(rows[i].r, rows[i].v, rows[i].d);
      n = 1;
      while (cur !== 1'b1 && n < 700)
      begin
        @(negedge clk);
        n++;
      end
      chk(16'(n), 16'd601);
      chk(16'(kind), 16'(rows[i].k));
      wait_done();
      chk(16'(rx_width), 16'(rows[i].w));
      chk(16'(rx_kind), 16'(rows[i].k));
      chk({busy, dsup, hsup}, {13'h0000, 1'b0, i >= 1, 1'b1});
    end
    edge_in(1'b1, 1'b1, 1'b1);
    repeat (300) @(negedge clk);
    edge_in(1'b1, 1'b1, 1'b0);
    wait_done();
    chk(16'(rx_width), 16'h0E10);
    repeat (700) @(negedge clk);
    chk({cur, busy}, 16'h0000);
    edge_in(1'b1, 1'b1, 1'b0);
    repeat (700) @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    chk({cur, busy, dsup, hsup, 2'(kind)}, 16'h0004);
    rst = 1'b0;
    give_verdict();
  end
endmodule
`default_nettype wire
